// file: shared/p3m_pkg.sv
`default_nettype none
package p3m_pkg;

    // ====================
    // Pins and register indexes
    // ====================
    localparam int PIN_W = 10;
    localparam logic [9:0] PIN_PRESENT = 10'h33f;
    localparam logic [9:0] PIN_OPEN_DRAIN = 10'h300;
    localparam int PIN_TX = 0;
    localparam int PIN_RX = 1;
    localparam int PIN_CLK = 2;
    localparam int PIN_T0 = 3;
    localparam int PIN_T1 = 4;
    localparam int PIN_T2 = 5;
    localparam int PIN_SDA = 8;
    localparam int PIN_SCL = 9;

    // Register indexes; the byte address is four times the index.
    localparam logic [31:0] IDX_MODE = 32'hfffff446;
    localparam logic [31:0] IDX_MODE_HIGH = 32'hfffff447;
    localparam logic [31:0] IDX_OD_FUNC = 32'hfffff4a7;
    localparam logic [31:0] IDX_CHOICE = 32'hfffff4a8;
    localparam logic [31:0] IDX_STATUS = 32'hfffff4a9;

    // ====================
    // Reset values, masks and field positions
    // ====================
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] MODE_WMASK = 16'h033f;
    localparam logic [1:0] OD_RESET = 2'h0;
    localparam logic [15:0] CHOICE_RESET = 16'h0000;
    localparam logic [15:0] CHOICE_WMASK = 16'h183c;
    localparam int CHOICE_EXT_POS = 8;
    localparam int STAT_ALT_POS = 16;

    // ====================
    // Carriers to and from the peripherals
    // ====================
    typedef struct packed {
        logic serial_tx_out;
        logic timer_a_output;
        logic timer_b_output;
        logic sec_timer_out0;
        logic sec_timer_out1;
        logic two_wire_data_out;
        logic two_wire_clock_out;
    } p3m_periph_drive_t;

    typedef struct packed {
        logic serial_rx_in;
        logic ext_interrupt_seven_in;
        logic serial_ext_clock_in;
        logic adc_trigger_in;
        logic timer_a_capture_in0;
        logic timer_a_capture_in1;
        logic timer_b_capture_in0;
        logic sec_timer_in0;
        logic sec_timer_in1;
        logic two_wire_data_in;
        logic two_wire_clock_in;
    } p3m_periph_sense_t;

    // Level seen by a peripheral whose pin is not routed.
    localparam p3m_periph_sense_t SENSE_PARKED = '{
        serial_rx_in: 1'b1,
        two_wire_data_in: 1'b1,
        two_wire_clock_in: 1'b1,
        default: 1'b0
    };

endpackage : p3m_pkg
`default_nettype wire

// file: hdl/p3m_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

// ====================
// One pin driver
// ====================
module p3m_pin_cell #(
    parameter bit OPEN_DRAIN = 1'b0
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Selection
    input wire logic i_alt_sel,
    input wire logic i_alt_drive,
    input wire logic i_alt_value,
    // Port side
    input wire logic i_port_latch,
    input wire logic i_port_dir_in,
    // Pin
    output logic o_pin_out,
    output logic o_pin_oe_n
);

    logic drive_en;
    logic drive_val;
    logic pin_out_d;
    logic pin_oe_n_d;

    always_comb
    begin
        if (i_alt_sel)
        begin
            drive_en = i_alt_drive;
            drive_val = i_alt_value;
        end
        else
        begin
            drive_en = ~i_port_dir_in;
            drive_val = i_port_latch;
        end
        if (OPEN_DRAIN)
        begin
            // Open-drain: a one releases the pin.
            pin_out_d = 1'b0;
            pin_oe_n_d = ~(drive_en & ~drive_val); // see [R14]
        end
        else
        begin
            pin_out_d = drive_val;
            pin_oe_n_d = ~drive_en;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_pin_out <= 1'b0;
            o_pin_oe_n <= 1'b1;
        end
        else
        begin
            o_pin_out <= pin_out_d;
            o_pin_oe_n <= pin_oe_n_d;
        end
    end

endmodule : p3m_pin_cell
`default_nettype wire

// file: hdl/p3m_port3_pin_function_select.sv
// How it works
// [R1] 16-bit mode register, high byte also at next index; resets to zero.
// [R2] Next-index byte view holds mode bits 8 to 15 as bits 0 to 7.
// [R3] Word access with byte strobes, plus low and high byte views; the code has only the high byte view, at the next index.
// [R4] Pin 0: set gives serial transmit output, clear gives port.
// [R5] Pin 1: set feeds serial receive and interrupt seven.
// [R6] Pin 2: set gives serial clock in, trigger in or timer output.
// [R7] Pin 3: set gives timer capture, timer output, second timer in or out.
// [R8] Pin 4: set gives timer capture, timer output, second timer in or out.
// [R9] Pin 5: set gives timer capture input or timer output.
// [R10] Mode bits 8 and 9 select two-wire data and clock.
// [R11] Mode bits 6, 7 and 10 to 15 read zero, change nothing.
// [R12] Software disables interrupt-seven edges while pin 1 is serial receive.
// [R13] Software stops the receiver while pin 1 is interrupt seven.
// [R14] Function bit: port or alternate on pins 8, 9; always open-drain.
// [R15] Software sets latch, function bit, then mode bit.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module p3m_port3_pin_function_select (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Port latch and direction from the port registers
    input wire logic [p3m_pkg::PIN_W-1:0] i_port_latch,
    input wire logic [p3m_pkg::PIN_W-1:0] i_port_dir_in,
    // Pins
    input wire logic [p3m_pkg::PIN_W-1:0] i_pin_in,
    output logic [p3m_pkg::PIN_W-1:0] o_pin_out,
    output logic [p3m_pkg::PIN_W-1:0] o_pin_oe_n,
    // Peripherals
    input wire p3m_pkg::p3m_periph_drive_t i_periph_drive,
    output p3m_pkg::p3m_periph_sense_t o_periph_sense,
    // Pins currently handed to an alternate function
    output logic [p3m_pkg::PIN_W-1:0] o_alt_active
);

    // ====================
    // Byte addresses
    // ====================
    localparam logic [31:0] ADDR_MODE = p3m_pkg::IDX_MODE << 2;
    localparam logic [31:0] ADDR_MODE_HIGH = p3m_pkg::IDX_MODE_HIGH << 2;
    localparam logic [31:0] ADDR_OD_FUNC = p3m_pkg::IDX_OD_FUNC << 2;
    localparam logic [31:0] ADDR_CHOICE = p3m_pkg::IDX_CHOICE << 2;
    localparam logic [31:0] ADDR_STATUS = p3m_pkg::IDX_STATUS << 2;

    // ====================
    // Declarations
    // ====================
    logic [15:0] mode_q;
    logic [15:0] mode_d;
    logic [1:0] od_func_q;
    logic [1:0] od_func_d;
    logic [15:0] choice_q;
    logic [15:0] choice_d;
    logic [p3m_pkg::PIN_W-1:0] pin_level_q;
    logic setup_phase;
    logic wr_commit;
    logic hit_mode;
    logic hit_mode_high;
    logic hit_od_func;
    logic hit_choice;
    logic hit_status;
    logic hit_any;
    logic [31:0] rdata_d;
    logic [p3m_pkg::PIN_W-1:0] alt_sel;
    logic [p3m_pkg::PIN_W-1:0] alt_drive;
    logic [p3m_pkg::PIN_W-1:0] alt_value;
    logic [1:0] pick3;
    logic [1:0] pick4;
    p3m_pkg::p3m_periph_sense_t sense_d;

    // ====================
    // APB decode
    // ====================
    assign setup_phase = i_psel & ~i_penable;
    // Writes land at the edge where pready is seen high.
    assign wr_commit = i_psel & i_penable & o_pready & i_pwrite;

    assign hit_mode = (i_paddr == ADDR_MODE);
    assign hit_mode_high = (i_paddr == ADDR_MODE_HIGH);
    assign hit_od_func = (i_paddr == ADDR_OD_FUNC);
    assign hit_choice = (i_paddr == ADDR_CHOICE);
    assign hit_status = (i_paddr == ADDR_STATUS);
    assign hit_any = hit_mode | hit_mode_high | hit_od_func | hit_choice | hit_status;

    always_comb
    begin
        rdata_d = 32'h0;
        if (hit_mode)
        begin
            rdata_d[15:0] = mode_q; // see [R3]
        end
        else if (hit_mode_high)
        begin
            rdata_d[7:0] = mode_q[15:8]; // see [R2]
        end
        else if (hit_od_func)
        begin
            rdata_d[1:0] = od_func_q;
        end
        else if (hit_choice)
        begin
            rdata_d[15:0] = choice_q;
        end
        else if (hit_status)
        begin
            rdata_d[p3m_pkg::PIN_W-1:0] = pin_level_q;
            rdata_d[p3m_pkg::STAT_ALT_POS +: p3m_pkg::PIN_W] = o_alt_active;
        end
    end

    // ====================
    // APB answer in the first access cycle
    // ====================
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0;
        end
        else if (setup_phase)
        begin
            o_pready <= 1'b1;
            o_pslverr <= ~hit_any;
            o_prdata <= (i_pwrite || !hit_any) ? 32'h0 : rdata_d;
        end
        else
        begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0;
        end
    end

    // ====================
    // Mode register and its byte views
    // ====================
    always_comb
    begin
        mode_d = mode_q;
        if (wr_commit && hit_mode)
        begin
            if (i_pstrb[0])
            begin
                mode_d[7:0] = i_pwdata[7:0]; // see [R3]
            end
            if (i_pstrb[1])
            begin
                mode_d[15:8] = i_pwdata[15:8]; // see [R3]
            end
        end
        else if (wr_commit && hit_mode_high && i_pstrb[0])
        begin
            mode_d[15:8] = i_pwdata[7:0]; // see [R2]
        end
        mode_d = mode_d & p3m_pkg::MODE_WMASK; // see [R11]
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mode_q <= p3m_pkg::MODE_RESET; // see [R1]
        end
        else
        begin
            mode_q <= mode_d;
        end
    end

    // ====================
    // Open-drain function bits
    // ====================
    always_comb
    begin
        od_func_d = od_func_q;
        if (wr_commit && hit_od_func && i_pstrb[0])
        begin
            od_func_d = i_pwdata[1:0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            od_func_q <= p3m_pkg::OD_RESET;
        end
        else
        begin
            od_func_q <= od_func_d;
        end
    end

    // ====================
    // Alternate-function choice bits
    // ====================
    always_comb
    begin
        choice_d = choice_q;
        if (wr_commit && hit_choice)
        begin
            if (i_pstrb[0])
            begin
                choice_d[7:0] = i_pwdata[7:0];
            end
            if (i_pstrb[1])
            begin
                choice_d[15:8] = i_pwdata[15:8];
            end
        end
        choice_d = choice_d & p3m_pkg::CHOICE_WMASK;
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            choice_q <= p3m_pkg::CHOICE_RESET;
        end
        else
        begin
            choice_q <= choice_d;
        end
    end

    // ====================
    // Pin selection
    // ====================
    assign pick3 = {choice_q[p3m_pkg::CHOICE_EXT_POS + p3m_pkg::PIN_T0], choice_q[p3m_pkg::PIN_T0]};
    assign pick4 = {choice_q[p3m_pkg::CHOICE_EXT_POS + p3m_pkg::PIN_T1], choice_q[p3m_pkg::PIN_T1]};

    always_comb
    begin
        // Masked so unused mode bits never select.
        alt_sel = mode_q[p3m_pkg::PIN_W-1:0] & p3m_pkg::PIN_PRESENT; // see [R11]
        // Pins 8 and 9 need mode and function bits.
        alt_sel[p3m_pkg::PIN_SDA] = mode_q[p3m_pkg::PIN_SDA] & od_func_q[0]; // see [R10] [R14]
        alt_sel[p3m_pkg::PIN_SCL] = mode_q[p3m_pkg::PIN_SCL] & od_func_q[1]; // see [R10] [R14]
    end

    always_comb
    begin
        alt_drive = '0;
        alt_value = '0;
        alt_drive[p3m_pkg::PIN_TX] = 1'b1; // see [R4]
        alt_value[p3m_pkg::PIN_TX] = i_periph_drive.serial_tx_out;
        alt_drive[p3m_pkg::PIN_CLK] = choice_q[p3m_pkg::PIN_CLK]; // see [R6]
        alt_value[p3m_pkg::PIN_CLK] = i_periph_drive.timer_b_output;
        case (pick3)
            2'h1:
            begin
                alt_drive[p3m_pkg::PIN_T0] = 1'b1; // see [R7]
                alt_value[p3m_pkg::PIN_T0] = i_periph_drive.timer_a_output;
            end
            2'h3:
            begin
                alt_drive[p3m_pkg::PIN_T0] = 1'b1; // see [R7]
                alt_value[p3m_pkg::PIN_T0] = i_periph_drive.sec_timer_out0;
            end
            default:
            begin
                alt_drive[p3m_pkg::PIN_T0] = 1'b0;
            end
        endcase
        case (pick4)
            2'h1:
            begin
                alt_drive[p3m_pkg::PIN_T1] = 1'b1; // see [R8]
                alt_value[p3m_pkg::PIN_T1] = i_periph_drive.timer_a_output;
            end
            2'h3:
            begin
                alt_drive[p3m_pkg::PIN_T1] = 1'b1; // see [R8]
                alt_value[p3m_pkg::PIN_T1] = i_periph_drive.sec_timer_out1;
            end
            default:
            begin
                alt_drive[p3m_pkg::PIN_T1] = 1'b0;
            end
        endcase
        alt_drive[p3m_pkg::PIN_T2] = choice_q[p3m_pkg::PIN_T2]; // see [R9]
        alt_value[p3m_pkg::PIN_T2] = i_periph_drive.timer_b_output;
        // Two-wire outputs pull low only.
        alt_drive[p3m_pkg::PIN_SDA] = 1'b1; // see [R10]
        alt_value[p3m_pkg::PIN_SDA] = i_periph_drive.two_wire_data_out;
        alt_drive[p3m_pkg::PIN_SCL] = 1'b1; // see [R10]
        alt_value[p3m_pkg::PIN_SCL] = i_periph_drive.two_wire_clock_out;
    end

    // ====================
    // Pin drivers
    // ====================
    generate
        for (genvar g = 0; g < p3m_pkg::PIN_W; g++)
        begin : g_pin
            p3m_pin_cell #(
                .OPEN_DRAIN(p3m_pkg::PIN_OPEN_DRAIN[g])
            ) u_cell (
                .i_mclk(i_mclk),
                .i_reset_n(i_reset_n),
                .i_alt_sel(alt_sel[g]),
                .i_alt_drive(alt_drive[g]),
                .i_alt_value(alt_value[g]),
                // Absent pins never drive.
                .i_port_latch(i_port_latch[g]), // see [R15]
                .i_port_dir_in(i_port_dir_in[g] | ~p3m_pkg::PIN_PRESENT[g]),
                .o_pin_out(o_pin_out[g]),
                .o_pin_oe_n(o_pin_oe_n[g])
            );
        end
    endgenerate

    // ====================
    // Pin levels to the peripherals
    // ====================
    always_comb
    begin
        sense_d = p3m_pkg::SENSE_PARKED;
        if (alt_sel[p3m_pkg::PIN_RX])
        begin
            // Both users see the pin; software keeps only one active.
            sense_d.serial_rx_in = i_pin_in[p3m_pkg::PIN_RX]; // see [R5] [R13]
            sense_d.ext_interrupt_seven_in = i_pin_in[p3m_pkg::PIN_RX]; // see [R5] [R12]
        end
        if (alt_sel[p3m_pkg::PIN_CLK] && !choice_q[p3m_pkg::PIN_CLK])
        begin
            sense_d.serial_ext_clock_in = i_pin_in[p3m_pkg::PIN_CLK]; // see [R6]
            sense_d.adc_trigger_in = i_pin_in[p3m_pkg::PIN_CLK];
        end
        if (alt_sel[p3m_pkg::PIN_T0] && pick3 == 2'h0)
        begin
            sense_d.timer_a_capture_in0 = i_pin_in[p3m_pkg::PIN_T0]; // see [R7]
        end
        if (alt_sel[p3m_pkg::PIN_T0] && pick3 == 2'h2)
        begin
            sense_d.sec_timer_in0 = i_pin_in[p3m_pkg::PIN_T0]; // see [R7]
        end
        if (alt_sel[p3m_pkg::PIN_T1] && pick4 == 2'h0)
        begin
            sense_d.timer_a_capture_in1 = i_pin_in[p3m_pkg::PIN_T1]; // see [R8]
        end
        if (alt_sel[p3m_pkg::PIN_T1] && pick4 == 2'h2)
        begin
            sense_d.sec_timer_in1 = i_pin_in[p3m_pkg::PIN_T1]; // see [R8]
        end
        if (alt_sel[p3m_pkg::PIN_T2] && !choice_q[p3m_pkg::PIN_T2])
        begin
            sense_d.timer_b_capture_in0 = i_pin_in[p3m_pkg::PIN_T2]; // see [R9]
        end
        if (alt_sel[p3m_pkg::PIN_SDA])
        begin
            sense_d.two_wire_data_in = i_pin_in[p3m_pkg::PIN_SDA]; // see [R10]
        end
        if (alt_sel[p3m_pkg::PIN_SCL])
        begin
            sense_d.two_wire_clock_in = i_pin_in[p3m_pkg::PIN_SCL]; // see [R10]
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_periph_sense <= p3m_pkg::SENSE_PARKED;
        end
        else
        begin
            o_periph_sense <= sense_d;
        end
    end

    // ====================
    // Status
    // ====================
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pin_level_q <= '0;
            o_alt_active <= '0;
        end
        else
        begin
            pin_level_q <= i_pin_in & p3m_pkg::PIN_PRESENT;
            o_alt_active <= alt_sel;
        end
    end

endmodule : p3m_port3_pin_function_select
`default_nettype wire

// file: sim/p3m_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module p3m_monitor (
    // Clock, reset and bus
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Pins and peripherals
    input wire logic [p3m_pkg::PIN_W-1:0] i_port_dir_in,
    input wire logic [p3m_pkg::PIN_W-1:0] i_pin_in,
    input wire logic [p3m_pkg::PIN_W-1:0] o_pin_out,
    input wire logic [p3m_pkg::PIN_W-1:0] o_pin_oe_n,
    input wire p3m_pkg::p3m_periph_drive_t i_periph_drive,
    input wire p3m_pkg::p3m_periph_sense_t o_periph_sense,
    input wire logic [p3m_pkg::PIN_W-1:0] o_alt_active
);
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);
    // ====================
    // Bus answers
    sequence setup_s;
        i_psel && !i_penable;
    endsequence
    sequence answer_s;
        o_pready ##1 !o_pready;
    endsequence
    ready_pulse_a: assert property (setup_s |=> answer_s)
        else $error("pready not a one-cycle answer");
    idle_rdata_a: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside an answer");
    err_data_a: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("error answer malformed");
    // ====================
    // Pin routing
    tx_route_a: assert property (o_alt_active[0] && $past(o_alt_active[0])
        && $stable(i_periph_drive.serial_tx_out)
        |-> !o_pin_oe_n[0] && o_pin_out[0] == i_periph_drive.serial_tx_out)
        else $error("pin 0 not serial transmit");
    rx_route_a: assert property (o_alt_active[1] && $past(o_alt_active[1])
        && $stable(i_pin_in[1]) |-> o_periph_sense.serial_rx_in == i_pin_in[1]
        && o_periph_sense.ext_interrupt_seven_in == i_pin_in[1])
        else $error("pin 1 not fed to receive and interrupt");
    rx_parked_a: assert property (!o_alt_active[1] && $past(!o_alt_active[1])
        |-> o_periph_sense.serial_rx_in && !o_periph_sense.ext_interrupt_seven_in)
        else $error("pin 1 leaks in port mode");
    port_drive_a: assert property (!o_alt_active[2] && $past(!o_alt_active[2])
        && $past(i_reset_n) && $stable(i_port_dir_in[2])
        |-> o_pin_oe_n[2] == i_port_dir_in[2])
        else $error("pin 2 direction ignored");
    unused_pins_a: assert property (o_alt_active[7:6] == 2'b00
        && o_pin_oe_n[7:6] == 2'b11)
        else $error("absent pins active");
    od_low_a: assert property (o_pin_out[9:8] == 2'b00)
        else $error("open-drain pin drives high");
    od_alt_a: assert property (o_alt_active[8] && $past(o_alt_active[8])
        && $stable(i_periph_drive.two_wire_data_out)
        |-> o_pin_oe_n[8] == i_periph_drive.two_wire_data_out)
        else $error("pin 8 not following two-wire data");
endmodule : p3m_monitor
bind p3m_port3_pin_function_select p3m_monitor u_mon (.i_mclk, .i_reset_n, .i_psel,
    .i_penable, .o_prdata, .o_pready, .o_pslverr, .i_port_dir_in, .i_pin_in, .o_pin_out,
    .o_pin_oe_n, .i_periph_drive, .o_periph_sense, .o_alt_active);
`default_nettype wire

// file: sim/p3m_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module p3m_far_side (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Chip side and outside drivers
    input wire logic [p3m_pkg::PIN_W-1:0] i_pin_out,
    input wire logic [p3m_pkg::PIN_W-1:0] i_pin_oe_n,
    input wire logic [p3m_pkg::PIN_W-1:0] i_ext_oe,
    input wire logic [p3m_pkg::PIN_W-1:0] i_ext_level,
    // Resolved pin levels
    output logic [p3m_pkg::PIN_W-1:0] o_pin_level
);
    logic [p3m_pkg::PIN_W-1:0] last_q;
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            last_q <= '0;
        else
            last_q <= o_pin_level;
    end
    // Floating pins show their inverse level; open-drain pins are pulled up.
    always_comb
    begin
        for (int n = 0; n < p3m_pkg::PIN_W; n++)
        begin
            if (!i_pin_oe_n[n])
                o_pin_level[n] = i_pin_out[n];
            else if (i_ext_oe[n])
                o_pin_level[n] = i_ext_level[n];
            else if (p3m_pkg::PIN_OPEN_DRAIN[n])
                o_pin_level[n] = 1'b1;
            else
                o_pin_level[n] = ~last_q[n];
        end
    end
endmodule : p3m_far_side
`default_nettype wire

// file: sim/tb_port3_pin_function_select.sv
`timescale 1ns/1ps
`default_nettype none
module tb_port3_pin_function_select;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic [9:0] latch = 10'h0, dir_in = 10'h3ff, ext_oe = 10'h0, ext_lvl = 10'h0;
    logic [9:0] pin_in, pin_out, oe_n, alt;
    p3m_pkg::p3m_periph_drive_t drv = '0;
    p3m_pkg::p3m_periph_sense_t sns;
    int errors = 0;
    int checks = 0;
    localparam logic [31:0] A_MODE = p3m_pkg::IDX_MODE << 2;
    localparam logic [31:0] A_HIGH = p3m_pkg::IDX_MODE_HIGH << 2;
    localparam logic [31:0] A_OD = p3m_pkg::IDX_OD_FUNC << 2;
    localparam logic [31:0] A_CH = p3m_pkg::IDX_CHOICE << 2;

    always #5 clk = ~clk;

    p3m_port3_pin_function_select dut (.i_mclk(clk), .i_reset_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_port_latch(latch), .i_port_dir_in(dir_in), .i_pin_in(pin_in), .o_pin_out(pin_out),
        .o_pin_oe_n(oe_n), .i_periph_drive(drv), .o_periph_sense(sns), .o_alt_active(alt));
    p3m_far_side far (.i_mclk(clk), .i_reset_n(rst_n), .i_pin_out(pin_out),
        .i_pin_oe_n(oe_n), .i_ext_oe(ext_oe), .i_ext_level(ext_lvl), .o_pin_level(pin_in));

    // ====================
    // Shared tasks
    task automatic end_of_test();
        if (errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s got %h", $time, what, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16)
        begin
            errors++;
            $display("unexpected at %0t: no pready", $time);
            end_of_test();
        end
        @(posedge clk);
    endtask : apb

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(rd, exp, what);
    endtask : rchk

    // ====================
    // Scenarios
    task automatic t_regs();
        rchk(A_MODE, 32'h0, "mode reset");
        apb(1'b1, A_MODE, 32'hffff, 4'h3);
        rchk(A_MODE, 32'h33f, "mode mask");
        rchk(A_HIGH, 32'h3, "high view");
        apb(1'b1, A_HIGH, 32'h1, 4'h1);
        apb(1'b1, A_MODE, 32'h0, 4'h2);
        rchk(A_MODE, 32'h3f, "lane write");
        apb(1'b1, A_HIGH, 32'h2, 4'h0);
        rchk(A_MODE, 32'h3f, "lane off");
        apb(1'b1, 32'h10, 32'hffffffff, 4'hf);
        chk({31'h0, er}, 32'h1, "unmapped");
        apb(1'b1, A_MODE, 32'h0, 4'h3);
    endtask : t_regs

    task automatic t_tx();
        drv.serial_tx_out <= 1'b1;
        dir_in[0] <= 1'b0;
        apb(1'b1, A_MODE, 32'h1, 4'h3);
        repeat (3) @(posedge clk);
        chk({30'h0, oe_n[0], pin_out[0]}, 32'h1, "tx high");
        drv.serial_tx_out <= 1'b0;
        latch[0] <= 1'b1;
        repeat (2) @(posedge clk);
        chk({30'h0, oe_n[0], pin_out[0]}, 32'h0, "tx low");
        apb(1'b1, A_MODE, 32'h0, 4'h3);
        repeat (3) @(posedge clk);
        chk({30'h0, oe_n[0], pin_out[0]}, 32'h1, "port latch");
        dir_in[0] <= 1'b1;
    endtask : t_tx

    // Pin 1 routed: serial receive and interrupt seven both follow the pin.
    task automatic t_rx();
        ext_oe[1] <= 1'b1;
        apb(1'b1, A_MODE, 32'h2, 4'h3);
        repeat (3) @(posedge clk);
        chk({30'h0, sns.serial_rx_in, sns.ext_interrupt_seven_in}, 32'h0, "rx low");
        ext_lvl[1] <= 1'b1;
        repeat (2) @(posedge clk);
        chk({30'h0, sns.serial_rx_in, sns.ext_interrupt_seven_in}, 32'h3, "rx high");
        ext_lvl[1] <= 1'b0;
        apb(1'b1, A_MODE, 32'h0, 4'h3);
        repeat (3) @(posedge clk);
        chk({30'h0, sns.serial_rx_in, sns.ext_interrupt_seven_in}, 32'h2, "parked");
    endtask : t_rx

    task automatic t_tim();
        ext_oe[5:2] <= 4'hf;
        ext_lvl[5:2] <= 4'hf;
        drv.timer_a_output <= 1'b1;
        drv.sec_timer_out1 <= 1'b1;
        apb(1'b1, A_MODE, 32'h3c, 4'h3);
        for (int e = 0; e < 4; e++)
        begin
            apb(1'b1, A_CH, (e[0] ? 32'h18 : 32'h0) | (e[1] ? 32'h1800 : 32'h0), 4'h3);
            ext_oe[4:3] <= e[0] ? 2'b00 : 2'b11;
            repeat (3) @(posedge clk);
            if (e[0])
                chk({28'h0, oe_n[4:3], pin_out[4:3]}, e[1] ? 32'h2 : 32'h3, "t out");
            else
                chk({28'h0, oe_n[4:3], e[1] ? {sns.sec_timer_in0, sns.sec_timer_in1} :
                    {sns.timer_a_capture_in0, sns.timer_a_capture_in1}}, 32'hf, "t in");
        end
        apb(1'b1, A_CH, 32'h0, 4'h3);
        ext_oe[4:3] <= 2'b11;
        repeat (3) @(posedge clk);
        chk({29'h0, sns.serial_ext_clock_in, sns.adc_trigger_in, sns.timer_b_capture_in0},
            32'h7, "p2 p5 in");
        ext_oe[5:2] <= 4'h0;
        apb(1'b1, A_CH, 32'h24, 4'h3);
        rchk(A_CH, 32'h24, "choice");
        repeat (3) @(posedge clk);
        chk({28'h0, oe_n[5], oe_n[2], pin_out[5], pin_out[2]}, 32'h0, "p2 p5 out");
        apb(1'b1, A_MODE, 32'h0, 4'h3);
        repeat (3) @(posedge clk);
        chk({28'h0, oe_n[5:2]}, 32'hf, "port again");
        apb(1'b1, A_CH, 32'h0, 4'h3);
    endtask : t_tim

    task automatic t_od();
        latch[9:8] <= 2'b11;
        apb(1'b1, A_OD, 32'h3, 4'h1);
        apb(1'b1, A_MODE, 32'h100, 4'h3);
        repeat (3) @(posedge clk);
        chk({30'h0, alt[9:8]}, 32'h1, "sda only");
        chk({30'h0, oe_n[8], pin_out[8]}, 32'h0, "sda low");
        drv.two_wire_data_out <= 1'b1;
        repeat (3) @(posedge clk);
        chk({29'h0, oe_n[8], pin_out[8], sns.two_wire_data_in}, 32'h5, "sda free");
        apb(1'b1, A_OD, 32'h0, 4'h1);
        repeat (3) @(posedge clk);
        chk({30'h0, alt[9:8]}, 32'h0, "func clear");
        apb(1'b1, A_MODE, 32'h0, 4'h3);
    endtask : t_od

    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_tx();
        t_rx();
        t_tim();
        t_od();
        end_of_test();
    end
endmodule : tb_port3_pin_function_select
`default_nettype wire
